/* verilog/xcvr_seq_pkg.sv */
package xcvr_seq_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int BUSY_CYCLES = 20;
  localparam int PWRDN_MIN_NS = 1000;
  localparam int PWRDN_CYCLES = (PWRDN_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int LTD_WAIT_CYCLES = 64;
  localparam int CNT_W = 12;
endpackage

/* verilog/xcvr_seq_if.sv */
`timescale 1ns/100ps
interface xcvr_seq_if;
  logic pwrdn;
  logic tx_dig_rst;
  logic rx_dig_rst;
  logic rx_ana_rst;
  logic freq_locked;
  logic busy;
  logic cfg_req;
  logic per_chan_clk;
  modport channel (input pwrdn, tx_dig_rst, rx_dig_rst, rx_ana_rst, cfg_req,
    output freq_locked, busy, per_chan_clk);
  modport ctrl (output pwrdn, tx_dig_rst, rx_dig_rst, rx_ana_rst, cfg_req,
    input freq_locked, busy, per_chan_clk);
endinterface

/* verilog/xcvr_channel_end.sv */
`timescale 1ns/100ps
// Functional notes
// [RULE_01] Busy falling marks offset cancellation done
// [RULE_02] Power-down stays low during cancellation
// [RULE_03] Busy at power-up, later only on access
// [RULE_04] Without power-down, controller sequences three resets
// [RULE_05] Power-down alone held at least 1 us
// [RULE_06] Digital receive reset may follow lock
// [RULE_07] Busy drops about twenty cycles after rising
// [RULE_08] Per-channel mode: own transmit clock reads FIFO
// [RULE_09] Reconfiguration clock free running, not derived
// [RULE_10] Hold receive reset until idle and locked; a restart together with a config access does not wait for the busy it raises
module xcvr_channel_end #(
  parameter int BUSY_LEN = xcvr_seq_pkg::BUSY_CYCLES,
  parameter int LOCK_LEN = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Link
  xcvr_seq_if.channel lnk,
  // User side
  input wire logic per_chan_sel,
  input wire logic lock_in_async,
  output logic cal_done,
  output logic fifo_rd_own_clk
);
  initial
  begin
    if (BUSY_LEN < 1 || BUSY_LEN > 255 || LOCK_LEN < 1 || LOCK_LEN > 255)
      $error("Counts out of range");
  end

  // ----------------------------------------
  // Busy sequencing
  // ----------------------------------------
  logic powerup_pending;
  logic busy_r;
  logic [7:0] busy_cnt;
  logic lock_s1;
  logic lock_s2;
  logic locked_r;

  // Power-up calibration once, later only on access
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      powerup_pending <= 1'b1;
      busy_r <= 1'b0;
      busy_cnt <= 8'h00;
    end
    else if (ce)
    begin
      if (!busy_r && ((powerup_pending && !lnk.pwrdn) || lnk.cfg_req)) // [RULE_03] [RULE_02]
      begin
        busy_r <= 1'b1;
        busy_cnt <= 8'h00;
        powerup_pending <= 1'b0;
      end
      else if (busy_r)
      begin
        busy_cnt <= busy_cnt + 8'h01;
        if (busy_cnt == 8'(BUSY_LEN - 1))
          busy_r <= 1'b0; // [RULE_07] [RULE_01]
      end
    end
  end

  // Lock pin from outside is synchronised first
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      lock_s1 <= 1'b0;
      lock_s2 <= 1'b0;
      locked_r <= 1'b0;
      cal_done <= 1'b0;
      fifo_rd_own_clk <= 1'b0;
    end
    else if (ce)
    begin
      lock_s1 <= lock_in_async;
      lock_s2 <= lock_s1;
      locked_r <= lock_s2 && !lnk.rx_ana_rst && !lnk.pwrdn;
      cal_done <= !busy_r && !powerup_pending; // [RULE_01]
      fifo_rd_own_clk <= per_chan_sel; // [RULE_08]
    end
  end

  assign lnk.busy = busy_r;
  assign lnk.freq_locked = locked_r;
  assign lnk.per_chan_clk = fifo_rd_own_clk;
endmodule

/* verilog/xcvr_reset_ctrl.sv */
`timescale 1ns/100ps
module xcvr_reset_ctrl #(
  parameter int PWRDN_LEN = xcvr_seq_pkg::PWRDN_CYCLES,
  parameter int LTD_LEN = xcvr_seq_pkg::LTD_WAIT_CYCLES,
  parameter bit SKIP_LTD = 1'b0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Link
  xcvr_seq_if.ctrl lnk,
  // User side
  input wire logic start,
  input wire logic cfg_access,
  output logic ready
);
  initial
  begin
    if (PWRDN_LEN < 1 || PWRDN_LEN > 4095 || LTD_LEN < 1 || LTD_LEN > 4095)
      $error("Counts out of range");
  end

  // ----------------------------------------
  // Reset sequence
  // ----------------------------------------
  typedef enum logic [2:0] {S_PWRDN, S_ANA, S_CAL, S_LOCK, S_LTD, S_RUN} state_e;
  state_e state;
  logic [xcvr_seq_pkg::CNT_W-1:0] cnt;
  logic busy_q;
  logic pwrdn_r, txr_r, rxd_r, rxa_r, req_r;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state <= S_PWRDN;
      cnt <= '0;
      busy_q <= 1'b0;
      pwrdn_r <= 1'b1;
      txr_r <= 1'b1;
      rxd_r <= 1'b1;
      rxa_r <= 1'b1;
      ready <= 1'b0;
    end
    else if (ce)
    begin
      busy_q <= lnk.busy;
      unique case (state)
        S_PWRDN:
        begin
          cnt <= cnt + 1'b1;
          if (cnt == xcvr_seq_pkg::CNT_W'(PWRDN_LEN - 1))
          begin
            pwrdn_r <= 1'b0; // [RULE_05]
            txr_r <= 1'b0;
            state <= S_ANA;
          end
        end
        S_ANA:
        begin
          rxa_r <= 1'b0; // [RULE_04]
          state <= S_CAL;
        end
        // Power-down kept low while busy runs
        S_CAL:
          if (busy_q && !lnk.busy) // [RULE_01] [RULE_02]
            state <= S_LOCK;
        S_LOCK:
          if (lnk.freq_locked && !lnk.busy) // [RULE_10]
          begin
            cnt <= '0;
            state <= SKIP_LTD ? S_RUN : S_LTD; // [RULE_06]
            if (SKIP_LTD)
            begin
              rxd_r <= 1'b0;
              ready <= 1'b1;
            end
          end
        S_LTD:
        begin
          cnt <= cnt + 1'b1;
          if (cnt == xcvr_seq_pkg::CNT_W'(LTD_LEN - 1))
          begin
            rxd_r <= 1'b0; // [RULE_04]
            ready <= 1'b1;
            state <= S_RUN;
          end
        end
        S_RUN:
          if (start)
          begin
            // Restart redoes the receive digital reset only, not the transmit one; no new power-up busy
            rxd_r <= 1'b1;
            ready <= 1'b0;
            state <= S_LOCK;
          end
        default:
          state <= S_PWRDN;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      req_r <= 1'b0;
    else if (ce)
      req_r <= cfg_access && state == S_RUN;
  end

  assign lnk.pwrdn = pwrdn_r;
  assign lnk.tx_dig_rst = txr_r;
  assign lnk.rx_dig_rst = rxd_r;
  assign lnk.rx_ana_rst = rxa_r;
  assign lnk.cfg_req = req_r;
endmodule

/* verif/xcvr_seq_chk.sv */
`timescale 1ns/100ps
module xcvr_seq_chk (
  // Clock
  input wire logic mclk,
  input wire logic rst,
  // Link
  input wire logic pwrdn,
  input wire logic tx_dig_rst,
  input wire logic rx_dig_rst,
  input wire logic rx_ana_rst,
  input wire logic freq_locked,
  input wire logic busy,
  input wire logic cfg_req,
  input wire logic per_chan_clk
);
  // --
  // Checks
  // --
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  logic [xcvr_seq_pkg::CNT_W-1:0] pw_cnt;
  // Counts cycles of power-down so the minimum hold needs no long repetition
  always_ff @(posedge mclk)
  begin
    if (rst)
      pw_cnt <= '0;
    else if (pwrdn && pw_cnt != {xcvr_seq_pkg::CNT_W{1'b1}})
      pw_cnt <= pw_cnt + 1'b1;
  end
  sequence s_up;
    $fell(pwrdn);
  endsequence
  sequence s_pulse;
    ##19 busy ##1 !busy;
  endsequence
  a_busy_done: assert property ($fell(busy) |-> !pwrdn) else $error("busy end");
  a_pwrdn_quiet: assert property (busy |-> !pwrdn) else $error("pwrdn");
  a_busy_up: assert property (s_up |=> $rose(busy)) else $error("no busy");
  a_busy_cfg: assert property ($rose(cfg_req) && !busy |=> $rose(busy)) else $error("cfg");
  a_tx_order: assert property (s_up |-> $fell(tx_dig_rst)) else $error("tx");
  a_ana_order: assert property (s_up |=> $fell(rx_ana_rst)) else $error("ana");
  a_pwrdn_min: assert property (s_up |-> pw_cnt >= xcvr_seq_pkg::PWRDN_CYCLES) else $error("short");
  a_busy_len: assert property ($rose(busy) |-> s_pulse) else $error("len");
  a_rx_hold: assert property ($fell(rx_dig_rst) |-> freq_locked && !busy) else $error("rx");
endmodule

/* verif/tb_transceiver_reset_offset_cancel_seq.sv */
`timescale 1ns/100ps
module tb_transceiver_reset_offset_cancel_seq;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic sel = 1'b0;
  logic lock = 1'b0;
  logic acc = 1'b0;
  logic cal_done;
  logic own_clk;
  logic ready;
  logic ready2;
  logic go = 1'b0;
  logic seen = 1'b0;
  int num_errors = 0;
  int check_count = 0;
  int i;
  xcvr_seq_if lnk ();
  xcvr_seq_if lnk2 ();
  xcvr_channel_end xcvr_channel_end_inst (.mclk(mclk), .rst(rst), .ce(1'b1), .lnk(lnk),
    .per_chan_sel(sel), .lock_in_async(lock), .cal_done(cal_done), .fifo_rd_own_clk(own_clk));
  xcvr_reset_ctrl #(.LTD_LEN(4)) xcvr_reset_ctrl_inst (.mclk(mclk), .rst(rst),
    .ce(1'b1), .lnk(lnk), .start(go), .cfg_access(acc), .ready(ready));
  // Second pair exercises the shortcut that skips the lock-to-data wait
  xcvr_channel_end xcvr_channel_end_skip_inst (.mclk(mclk), .rst(rst), .ce(1'b1), .lnk(lnk2),
    .per_chan_sel(sel), .lock_in_async(lock), .cal_done(), .fifo_rd_own_clk());
  xcvr_reset_ctrl #(.LTD_LEN(4), .SKIP_LTD(1'b1)) xcvr_reset_ctrl_skip_inst (.mclk(mclk),
    .rst(rst), .ce(1'b1), .lnk(lnk2), .start(1'b0), .cfg_access(1'b0), .ready(ready2));
  xcvr_seq_chk xcvr_seq_chk_inst (.mclk(mclk), .rst(rst), .pwrdn(lnk.pwrdn),
    .tx_dig_rst(lnk.tx_dig_rst), .rx_dig_rst(lnk.rx_dig_rst), .rx_ana_rst(lnk.rx_ana_rst),
    .freq_locked(lnk.freq_locked), .busy(lnk.busy), .cfg_req(lnk.cfg_req),
    .per_chan_clk(lnk.per_chan_clk));
  // --
  // Tasks
  // --
  task final_report;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %0t got %b", $time, got);
    end
  endtask
  task bound;
    if (i >= 300)
    begin
      num_errors++;
      $display("mismatch %0t timeout", $time);
      final_report;
    end
  endtask
  task t_powerup;
    for (i = 0; i < 300 && lnk.busy !== 1'b1; i++) @(negedge mclk);
    bound;
    chk(lnk.pwrdn, 1'b0);
    chk(cal_done, 1'b0);
    for (i = 0; i < 300 && lnk.busy !== 1'b0; i++) @(negedge mclk);
    bound;
    // Lock held back so the reset must wait
    repeat (10) @(negedge mclk);
    chk(cal_done, 1'b1);
    chk(lnk.rx_dig_rst, 1'b1);
    lock = 1'b1;
    for (i = 0; i < 300 && lnk2.freq_locked !== 1'b1; i++) @(negedge mclk);
    bound;
    @(negedge mclk);
    chk(ready2, 1'b1);
    chk(lnk2.rx_dig_rst, 1'b0);
    for (i = 0; i < 300 && ready !== 1'b1; i++) @(negedge mclk);
    bound;
    chk(lnk.freq_locked, 1'b1);
    chk(lnk.rx_dig_rst, 1'b0);
  endtask
  task t_cfg;
    acc = 1'b1;
    @(negedge mclk);
    acc = 1'b0;
    for (i = 0; i < 300 && lnk.busy !== 1'b1; i++) @(negedge mclk);
    bound;
    for (i = 0; i < 300 && lnk.busy === 1'b1; i++) @(negedge mclk);
    bound;
    chk(i == xcvr_seq_pkg::BUSY_CYCLES, 1'b1);
  endtask
  task t_restart;
    go = 1'b1;
    @(negedge mclk);
    go = 1'b0;
    chk(lnk.rx_dig_rst, 1'b1);
    seen = 1'b0;
    for (i = 0; i < 300 && ready !== 1'b1; i++)
    begin
      seen = seen | (lnk.busy === 1'b1);
      @(negedge mclk);
    end
    bound;
    chk(seen, 1'b0);
    chk(lnk.rx_dig_rst, 1'b0);
  endtask
  task t_own;
    sel = 1'b1;
    repeat (2) @(negedge mclk);
    chk(own_clk, 1'b1);
    sel = 1'b0;
    repeat (2) @(negedge mclk);
    chk(own_clk, 1'b0);
  endtask
  initial
  begin
    forever #2.5 mclk = ~mclk;
  end
  initial
  begin
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    t_powerup;
    t_cfg;
    t_own;
    t_restart;
    final_report;
  end
endmodule
